// ==== cbm_code_bank_mapper.v ====
/*
 Code bank mapper: holds the bank select register and maps core fetch
 and constant accesses onto 128k bytes of banked flash.
 Assumes the core presents special function register accesses and
 code accesses as same-clock strobes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cbm_defs.vh"
module cbm_code_bank_mapper (
  input wire clk,
  input wire reset,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWData,
  output reg [7:0] sfrRData,
  output wire sfrHit,
  input wire [15:0] execPc,
  input wire fetchReq,
  input wire [15:0] fetchAddr,
  input wire constReq,
  input wire constWrite,
  input wire scratchSel,
  input wire [15:0] constAddr,
  input wire [7:0] programStoreControl,
  output reg [16:0] fetchFlashAddr,
  output reg fetchValid,
  output reg [16:0] constFlashAddr,
  output reg constValid,
  output reg constWriteEn,
  output reg constScratch,
  output reg reservedFault
);
  reg [1:0] fetchBankField_q;
  reg [1:0] constBankField_q;
  wire regSel;
  wire fromBank0;
  wire [16:0] fetchMapped;
  wire [16:0] constMapped;
  wire fetchRes;
  wire constRes;
  localparam [7:0] RESET_VAL = `CBM_BANK_SEL_RESET;

  ////////////////////////////////////////////////////////////////////
  // Register access on every page; the fetch bank field is written only while executing from the lower half
  assign regSel = (sfrAddr == `CBM_BANK_SEL_ADDR);
  assign sfrHit = regSel && (sfrRead || sfrWrite);
  assign fromBank0 = !execPc[`CBM_UPPER_BIT];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fetchBankField_q <= RESET_VAL[`CBM_FETCH_MSB:`CBM_FETCH_LSB];
      constBankField_q <= RESET_VAL[`CBM_CONST_MSB:`CBM_CONST_LSB];
    end else if (sfrWrite && regSel) begin
      constBankField_q <= sfrWData[`CBM_CONST_MSB:`CBM_CONST_LSB];
      if (fromBank0) begin
        fetchBankField_q <= sfrWData[`CBM_FETCH_MSB:`CBM_FETCH_LSB];
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sfrRData <= 8'h00;
    end else if (sfrRead && regSel) begin
      sfrRData <= {2'h0, constBankField_q, 2'h0, fetchBankField_q};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address mapping; fetch and constant paths kept apart by request type
  cbm_bank_decode fetchDecode (
    .codeAddr(fetchAddr),
    .bankSel(fetchBankField_q),
    .bypass(1'b0),
    .flashAddr(fetchMapped),
    .reservedHit(fetchRes)
  );

  cbm_bank_decode constDecode (
    .codeAddr(constAddr),
    .bankSel(constBankField_q),
    .bypass(scratchSel),
    .flashAddr(constMapped),
    .reservedHit(constRes)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fetchFlashAddr <= 17'h00000;
      fetchValid <= 1'b0;
      constFlashAddr <= 17'h00000;
      constValid <= 1'b0;
      constWriteEn <= 1'b0;
      constScratch <= 1'b0;
      reservedFault <= 1'b0;
    end else begin
      fetchValid <= fetchReq;
      constValid <= constReq && !constWrite ||
        constReq && constWrite && programStoreControl[`CBM_PROGRAM_STORE_CONTROL_WRITE_BIT];
      constWriteEn <= constReq && constWrite &&
        programStoreControl[`CBM_PROGRAM_STORE_CONTROL_WRITE_BIT];
      constScratch <= constReq && scratchSel;
      reservedFault <= (fetchReq && fetchRes) || (constReq && constRes);
      if (fetchReq) begin
        fetchFlashAddr <= fetchMapped;
      end
      if (constReq) begin
        constFlashAddr <= constMapped;
      end
    end
  end
endmodule // cbm_code_bank_mapper
`default_nettype wire

// ==== cbm_defs.vh ====
/*
 Constants of the code bank mapper: register address, field positions,
 reset value and memory geometry. Assumes inclusion by bare name.
*/
`ifndef CBM_DEFS_VH
`define CBM_DEFS_VH
`define CBM_BANK_SEL_ADDR 8'hb1
`define CBM_BANK_SEL_RESET 8'h11
`define CBM_BANK_SEL_MASK 8'h33
`define CBM_FETCH_LSB 0
`define CBM_FETCH_MSB 1
`define CBM_CONST_LSB 4
`define CBM_CONST_MSB 5
`define CBM_UPPER_BIT 15
`define CBM_RESERVED_BASE 17'h1fc00
`define CBM_PROGRAM_STORE_CONTROL_WRITE_BIT 0
`endif

// ==== cbm_bank_decode.v ====
/*
 Bank decoder: forms a 17-bit flash address from a 16-bit code address
 and a 2-bit upper-window bank. Purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cbm_defs.vh"
module cbm_bank_decode (
  input wire [15:0] codeAddr,
  input wire [1:0] bankSel,
  input wire bypass,
  output wire [16:0] flashAddr,
  output wire reservedHit
);
  wire upper;
  wire [1:0] bank;
  assign upper = codeAddr[`CBM_UPPER_BIT];
  // Lower half always bank 0; upper half takes the selected bank unless bypass is set
  assign bank = (upper && !bypass) ? bankSel : 2'h0;
  assign flashAddr = {bank, codeAddr[14:0]};
  assign reservedHit = (flashAddr >= `CBM_RESERVED_BASE) && !bypass;
endmodule // cbm_bank_decode
`default_nettype wire

// ==== cbm_core_model.sv ====
/* Core request model. Assumes a free-running clock. */
`timescale 1ns/1ns
`default_nettype none
module cbm_core_model (
  input wire logic clk,
  output logic fetchReq, constReq, constWrite, scratchSel,
  output logic [15:0] fetchAddr, constAddr
);
  initial {fetchReq, constReq, constWrite, scratchSel, fetchAddr, constAddr} = '0;
  task req(input logic f, c, w, s, input logic [15:0] a);
    @(negedge clk);
    {fetchReq, constReq, constWrite, scratchSel, fetchAddr, constAddr} = {f, c, w, s, a, a};
    @(negedge clk);
    {fetchReq, constReq, fetchAddr, constAddr} = {2'b00, ~a, ~a};
  endtask
endmodule // cbm_core_model
`default_nettype wire

// ==== cbm_mapper_monitor.sv ====
/* Mapper port checker. Assumes bind to the mapper. */
`timescale 1ns/1ns
`default_nettype none
module cbm_checker (
  input wire clk, reset, fetchReq, fetchValid, constReq, constWrite, constValid,
  input wire scratchSel, reservedFault, sfrHit, sfrRead, sfrWrite,
  input wire [7:0] sfrAddr, programStoreControl,
  input wire [15:0] fetchAddr, constAddr, input wire [16:0] fetchFlashAddr, constFlashAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_lowFetch; fetchReq && !fetchAddr[15]; endsequence
  a_fetch_late: assert property (fetchReq |=> fetchValid) else $error("late");
  a_fetch_spur: assert property (!fetchReq |=> !fetchValid) else $error("spur");
  a_low_fetch: assert property (s_lowFetch |=> fetchFlashAddr == {2'b00, $past(fetchAddr[14:0])})
    else $error("low");
  a_const_read: assert property (constReq && !constWrite |=> constValid) else $error("cr");
  a_const_lock: assert property (constReq && constWrite && !programStoreControl[0] |=> !constValid)
    else $error("lock");
  a_scratch_bank: assert property (constReq && (scratchSel || !constAddr[15])
    |=> constFlashAddr[16:15] == 2'b00) else $error("scr");
  a_hit_decode: assert property (sfrHit == ((sfrAddr == 8'hb1) && (sfrRead || sfrWrite)))
    else $error("hit");
  a_fault_cause: assert property (reservedFault |-> fetchFlashAddr >= 17'h1fc00
    || constFlashAddr >= 17'h1fc00) else $error("flt");
endmodule // cbm_checker
bind cbm_code_bank_mapper cbm_checker i_cbm_checker (.*);
`default_nettype wire

// ==== cbm_code_bank_mapper_tb_top.sv ====
/* Mapper bench. Assumes the core model and checker. */
`timescale 1ns/1ns
`default_nettype none
module cbm_code_bank_mapper_tb_top;
  logic clk = 0, reset = 1, sfrWrite = 0, sfrRead = 0, fetchReq, constReq, constWrite, scratchSel;
  logic [7:0] sfrAddr = 0, sfrWData = 0, programStoreControl = 0, sfrRData;
  logic [15:0] execPc = 0, fetchAddr, constAddr;
  logic [16:0] fetchFlashAddr, constFlashAddr;
  logic sfrHit, fetchValid, constValid, constWriteEn, constScratch, reservedFault;
  logic [7:0] rows [4] = '{8'h30, 8'h21, 8'h12, 8'h03};
  int errCount = 0, totalChecks = 0;
  cbm_code_bank_mapper i_cbm_code_bank_mapper (.*);
  cbm_core_model i_cbm_core_model (.*);
  initial forever #20 clk = ~clk;
  task chk(input string n, input logic [16:0] e, g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task sfr(input logic w, input logic [7:0] d, input logic [15:0] pc);
    @(negedge clk);
    {sfrWrite, sfrRead, sfrAddr, sfrWData, execPc} = {w, !w, 8'hb1, d, pc};
    @(negedge clk);
    {sfrWrite, sfrRead} = 2'b00;
  endtask
  task conclude;
    $display("Checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    sfr(0, 0, 0);
    chk("reset", 8'h11, sfrRData);
    foreach (rows[i]) begin
      sfr(1, rows[i], 16'h0100);
      i_cbm_core_model.req(1, 1, 0, 0, 16'h8004);
      chk("fetch", {rows[i][1:0], 15'h0004}, fetchFlashAddr);
      chk("fetch valid", 1, fetchValid);
      chk("const", {rows[i][5:4], 15'h0004}, constFlashAddr);
    end
    sfr(1, 8'hfc, 16'h8000);
    sfr(0, 0, 0);
    chk("upper write", 8'h33, sfrRData);
    i_cbm_core_model.req(1, 1, 0, 1, 16'hfc00);
    chk("fault", 1, reservedFault);
    chk("scratch", 17'h07c00, constFlashAddr);
    chk("scratch flag", 1, constScratch);
    i_cbm_core_model.req(1, 1, 1, 0, 16'h1234);
    chk("low", 17'h01234, fetchFlashAddr);
    chk("locked", 0, constWriteEn);
    chk("lock valid", 0, constValid);
    programStoreControl = 8'h01;
    i_cbm_core_model.req(0, 1, 1, 0, 16'h8001);
    chk("flash write", 1, constWriteEn);
    chk("write valid", 1, constValid);
    chk("write addr", 17'h18001, constFlashAddr);
    conclude;
  end
  initial begin
    #20000;
    errCount++;
    conclude;
  end
endmodule // cbm_code_bank_mapper_tb_top
`default_nettype wire
